// ===== rtl/hwi_pkg.sv
/*
  Constants for the high-voltage wake input and event interrupt block.
  Assumes a 100 MHz core clock derived from the internal oscillator.
*/
// How it works
// - Both rising and falling wake-pin crossings count as wake events.
// - Wake events interrupt in Normal/Stop, wake device in Sleep/Fail-Safe.
// - Static sensing always active; cyclic sensing only during timed window.
// - Each crossing restarts 16 us filter; accept only if stable till expiry.
// - Wake control enables pin wake; accepted events latch a status bit.
// - Level status shows pin level; cyclic sensing holds last sampled level.
// - GPIO as wake input uses same filter, latches secondary status.
// - Bias field: 00 none, 01 down, 10 up, 11 follows detected level.
// - Cyclic: sample at end of high-side switch on-time; change raises event.
// - Measurement mode routes pin voltage out; fail, GPIO, wake unavailable.
// - Measurement mode disables bias sources and blocks internal wake signal.
// - Measurement mode ignores bias and wake settings, writes still accepted.
// - Measurement mode blocks pin and GPIO wake status; holds level status cleared.
// - Pin sole wake source in measurement: sleep request fails to restart.
// - Interrupt drives low output for fixed pulse width, then releases.
// - Output stays high at least a minimum gap between pulses.
// - Raising an interrupt never changes operating mode.
// - Class bit: wake events only, or also latched failures.
// - Wake event interrupts only if its source is wake enabled.
// - Restart/fail-safe errors, power-on and state bits never interrupt.
// - No pulses in Restart/Fail-Safe/Sleep; Stop entry with wake bits pulses.
// - Status updates at pulse falling edge, or without pulse in Sleep/Fail-Safe; latched until read and cleared.
package hwi_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ          = 100;
  localparam int FILTER_TIME_US   = 16;
  localparam int PULSE_WIDTH_US   = 100;
  localparam int MIN_GAP_US       = 100;
  localparam int FILTER_CYCLES    = FILTER_TIME_US * CLK_MHZ;
  localparam int PULSE_CYCLES     = PULSE_WIDTH_US * CLK_MHZ;
  localparam int GAP_CYCLES       = MIN_GAP_US * CLK_MHZ;
  localparam int CNT_W            = 14;

  // ------------------------------------------------------------------
  // Bias select encodings and reset values
  // ------------------------------------------------------------------
  localparam logic [1:0] BIAS_NONE = 2'h0;
  localparam logic [1:0] BIAS_DOWN = 2'h1;
  localparam logic [1:0] BIAS_UP   = 2'h2;
  localparam logic [1:0] BIAS_AUTO = 2'h3;
  localparam logic [1:0] BIAS_RST  = 2'h0;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_INIT,
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_RESTART,
    MODE_FAILSAFE
  } hwi_mode_t;

endpackage

// ===== rtl/hwi_filter.sv
/*
  Wake input filter: a crossing restarts a timer, level accepted on expiry.
  Assumes a synchronised input in the core clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module hwi_filter #(
  parameter int CYCLES = hwi_pkg::FILTER_CYCLES
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic en,
  input  wire logic din,
  output logic      level,
  output logic      edge_evt
);
  logic [hwi_pkg::CNT_W-1:0] cnt;
  logic [hwi_pkg::CNT_W-1:0] next_cnt;
  logic                      seen;
  logic                      next_seen;
  logic                      next_level;
  logic                      next_edge_evt;

  always_comb begin
    next_cnt      = cnt;
    next_seen     = seen;
    next_level    = level;
    next_edge_evt = 1'b0;
    if (!en) begin
      next_cnt  = '0;
      next_seen = din;
      next_level = din;
    end else if (din != seen) begin
      // Crossing restarts the filter window
      next_seen = din;
      next_cnt  = hwi_pkg::CNT_W'(CYCLES - 1);
    end else if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
      if (cnt == hwi_pkg::CNT_W'(1) && din != level) begin
        next_level    = din;
        next_edge_evt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt      <= '0;
      seen     <= 1'b0;
      level    <= 1'b0;
      edge_evt <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      seen     <= next_seen;
      level    <= next_level;
      edge_evt <= next_edge_evt;
    end
  end

  filter_accept_a: assert property (@(posedge clk) disable iff (!arst_n)
    edge_evt |-> (level == $past(din)) && (level != $past(level)))
    else $error("filtered edge without stable input");
endmodule
`default_nettype wire

// ===== rtl/hwi_top.sv
/*
  Wake pin sensing, bias selection, measurement override and event interrupt.
  Assumes mode, pin and high-side switch inputs come from outside the clock
  domain; software status clears and settings are same-domain levels.
*/
`timescale 1ns/1ps
`default_nettype none
module hwi_top (
  input  wire logic       CORE_CLK,
  input  wire logic       ARST_N,
  input  wire logic       HV_WAKE_PIN,
  input  wire logic       GPIO_WAKE_PIN,
  input  wire logic       HS_SWITCH_ON,
  input  wire logic [2:0] MODE,
  input  wire logic       CYCLIC_SENSE,
  input  wire logic       PIN_WAKE_EN,
  input  wire logic       GPIO_IS_WAKE,
  input  wire logic       CAN_WAKE_EN,
  input  wire logic       TIMER_WAKE_EN,
  input  wire logic       CAN_WAKE_EVT,
  input  wire logic       TIMER_WAKE_EVT,
  input  wire logic       FAILURE_EVT,
  input  wire logic       FATAL_EVT,
  input  wire logic [1:0] BIAS_SELECT_FIELD,
  input  wire logic       HV_MEASURE_ENABLE,
  input  wire logic       INT_GLOBAL,
  input  wire logic       SLEEP_REQ,
  input  wire logic       FAIL_OUTPUT_TEST,
  input  wire logic       CLR_PRIMARY,
  input  wire logic       CLR_SECONDARY,
  input  wire logic       CLR_FAILURE,
  output logic [1:0]      WAKE_STATUS_PRIMARY,
  output logic            WAKE_STATUS_SECONDARY,
  output logic            FAILURE_STATUS,
  output logic            PIN_LEVEL_STATUS,
  output logic            PULL_UP_ON,
  output logic            PULL_DOWN_ON,
  output logic            MEASURE_ROUTE_ON,
  output logic            FAIL_TEST_DRIVE,
  output logic            DEVICE_WAKE,
  output logic            SPI_FAIL,
  output logic            RESTART_REQ,
  output logic            EVENT_OUT_N
);

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic [5:0] raw_in;
  logic [2:0] mode_d;
  logic [2:0] mode_q;
  assign raw_in = {MODE, HS_SWITCH_ON, GPIO_WAKE_PIN, HV_WAKE_PIN};
  wire logic [2:0] next_mode_q = (sync2[5:3] == mode_d) ? mode_d : mode_q;

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1  <= '0;
      sync2  <= '0;
      mode_d <= '0;
      mode_q <= '0;
    end else begin
      sync1  <= raw_in;
      sync2  <= sync1;
      mode_d <= sync2[5:3];
      mode_q <= next_mode_q;
    end
  end

  hwi_pkg::hwi_mode_t mode;
  logic pin_s;
  logic gpio_s;
  logic hs_s;
  assign mode   = hwi_pkg::hwi_mode_t'(mode_q);
  assign hs_s   = sync2[2];
  assign gpio_s = sync2[1];
  assign pin_s  = sync2[0];

  logic run_mode;
  logic low_mode;
  assign run_mode = (mode == hwi_pkg::MODE_NORMAL) || (mode == hwi_pkg::MODE_STOP);
  assign low_mode = (mode == hwi_pkg::MODE_SLEEP) || (mode == hwi_pkg::MODE_FAILSAFE);

  // ------------------------------------------------------------------
  // Wake detection
  // ------------------------------------------------------------------
  // Measurement mode gates the internal wake signal; settings stay writable
  logic pin_gate;
  logic static_en;
  assign pin_gate  = !HV_MEASURE_ENABLE;
  assign static_en = pin_gate && !CYCLIC_SENSE;

  logic pin_level;
  logic pin_edge;
  logic gpio_level;
  logic gpio_edge;

  hwi_filter #(.CYCLES(hwi_pkg::FILTER_CYCLES)) u_pin_filt (
    .clk      (CORE_CLK),
    .arst_n   (ARST_N),
    .en       (static_en),
    .din      (pin_s),
    .level    (pin_level),
    .edge_evt (pin_edge)
  );

  // Same filter for the GPIO used as a wake input
  hwi_filter #(.CYCLES(hwi_pkg::FILTER_CYCLES)) u_gpio_filt (
    .clk      (CORE_CLK),
    .arst_n   (ARST_N),
    .en       (GPIO_IS_WAKE && !HV_MEASURE_ENABLE),
    .din      (gpio_s),
    .level    (gpio_level),
    .edge_evt (gpio_edge)
  );

  // Cyclic sensing: sample at end of switch on-time
  logic cyc_level;
  logic next_cyc_level;
  logic cyc_edge;
  logic next_cyc_edge;
  logic hs_d;

  always_comb begin
    next_cyc_level = cyc_level;
    next_cyc_edge  = 1'b0;
    if (pin_gate && CYCLIC_SENSE && hs_d && !hs_s) begin
      next_cyc_level = pin_s;
      next_cyc_edge  = (pin_s != cyc_level);
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cyc_level <= 1'b0;
      cyc_edge  <= 1'b0;
      hs_d      <= 1'b0;
    end else begin
      cyc_level <= next_cyc_level;
      cyc_edge  <= next_cyc_edge;
      hs_d      <= hs_s;
    end
  end

  logic pin_evt;
  assign pin_evt = PIN_WAKE_EN && pin_gate && (CYCLIC_SENSE ? cyc_edge : pin_edge);

  // ------------------------------------------------------------------
  // Bias, level, measurement outputs
  // ------------------------------------------------------------------
  logic sense_level;
  assign sense_level = CYCLIC_SENSE ? cyc_level : pin_level;

  always_comb begin
    PULL_UP_ON   = 1'b0;
    PULL_DOWN_ON = 1'b0;
    if (pin_gate) begin
      case (BIAS_SELECT_FIELD)
        hwi_pkg::BIAS_DOWN: PULL_DOWN_ON = 1'b1;
        hwi_pkg::BIAS_UP:   PULL_UP_ON   = 1'b1;
        hwi_pkg::BIAS_AUTO: begin
          PULL_UP_ON   = pin_s;
          PULL_DOWN_ON = !pin_s;
        end
        default: ;
      endcase
    end
  end

  wire logic next_level_status = pin_gate && sense_level;

  assign MEASURE_ROUTE_ON = HV_MEASURE_ENABLE;
  assign FAIL_TEST_DRIVE  = FAIL_OUTPUT_TEST && !HV_MEASURE_ENABLE;
  assign RESTART_REQ      = SPI_FAIL;

  // Sole wake source is the pin when no other source is enabled
  logic sole_pin;
  logic next_spi_fail;
  assign sole_pin = PIN_WAKE_EN && !CAN_WAKE_EN && !TIMER_WAKE_EN && !GPIO_IS_WAKE;
  assign next_spi_fail = SPI_FAIL || (SLEEP_REQ && HV_MEASURE_ENABLE && sole_pin);

  // ------------------------------------------------------------------
  // Pending events and status latches
  // ------------------------------------------------------------------
  // Pending bits: {failure, gpio, timer, pin, can}
  logic [4:0] pend;
  logic [4:0] next_pend;
  logic [4:0] new_evt;
  logic       fire;
  logic       stop_entry;
  logic       mode_stop_d;

  assign new_evt = {FAILURE_EVT && INT_GLOBAL && !FATAL_EVT,
                    gpio_edge && GPIO_IS_WAKE,
                    TIMER_WAKE_EVT && TIMER_WAKE_EN,
                    pin_evt,
                    CAN_WAKE_EVT && CAN_WAKE_EN};
  assign stop_entry = (mode == hwi_pkg::MODE_STOP) && !mode_stop_d;

  always_comb begin
    next_pend = pend | new_evt;
    if (fire) begin
      next_pend = new_evt;
    end
  end

  logic [1:0] next_prim;
  logic       next_sec;
  logic       next_fail;
  always_comb begin
    // Clear first, then set: an update in the clear cycle wins
    next_prim = WAKE_STATUS_PRIMARY & ~{2{CLR_PRIMARY}};
    next_sec  = WAKE_STATUS_SECONDARY && !CLR_SECONDARY;
    next_fail = FAILURE_STATUS && !CLR_FAILURE;
    if (fire || low_mode) begin
      next_prim = next_prim | {pend[1], pend[0]};
      next_sec  = next_sec | pend[3];
      next_fail = next_fail | pend[4];
    end
  end

  // ------------------------------------------------------------------
  // Interrupt pulse sequencer
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {IRQ_IDLE, IRQ_PULSE, IRQ_GAP} hwi_irq_t;
  hwi_irq_t                  irq_st;
  hwi_irq_t                  next_irq_st;
  logic [hwi_pkg::CNT_W-1:0] irq_cnt;
  logic [hwi_pkg::CNT_W-1:0] next_irq_cnt;
  logic                      want;
  logic                      stop_req;
  logic                      next_stop_req;
  wire logic stop_hit = stop_entry && (|WAKE_STATUS_PRIMARY || WAKE_STATUS_SECONDARY);

  // A Stop entry seen during a pulse or gap is held until the next pulse
  assign want          = run_mode && ((|pend) || stop_req || stop_hit);
  assign next_stop_req = (stop_req || stop_hit) && run_mode && !fire;
  assign fire = (irq_st == IRQ_IDLE) && want;

  always_comb begin
    next_irq_st  = irq_st;
    next_irq_cnt = irq_cnt;
    case (irq_st)
      IRQ_IDLE: begin
        if (want) begin
          next_irq_st  = IRQ_PULSE;
          next_irq_cnt = hwi_pkg::CNT_W'(hwi_pkg::PULSE_CYCLES - 1);
        end
      end
      IRQ_PULSE: begin
        if (irq_cnt == '0) begin
          next_irq_st  = IRQ_GAP;
          next_irq_cnt = hwi_pkg::CNT_W'(hwi_pkg::GAP_CYCLES - 1);
        end else begin
          next_irq_cnt = irq_cnt - 1'b1;
        end
      end
      IRQ_GAP: begin
        if (irq_cnt == '0) begin
          next_irq_st = IRQ_IDLE;
        end else begin
          next_irq_cnt = irq_cnt - 1'b1;
        end
      end
      default: next_irq_st = IRQ_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_st                <= IRQ_IDLE;
      irq_cnt               <= '0;
      pend                  <= '0;
      mode_stop_d           <= 1'b0;
      stop_req              <= 1'b0;
      WAKE_STATUS_PRIMARY   <= '0;
      WAKE_STATUS_SECONDARY <= 1'b0;
      FAILURE_STATUS        <= 1'b0;
      PIN_LEVEL_STATUS      <= 1'b0;
      SPI_FAIL              <= 1'b0;
      DEVICE_WAKE           <= 1'b0;
    end else begin
      irq_st                <= next_irq_st;
      irq_cnt               <= next_irq_cnt;
      pend                  <= next_pend;
      mode_stop_d           <= (mode == hwi_pkg::MODE_STOP);
      stop_req              <= next_stop_req;
      WAKE_STATUS_PRIMARY   <= next_prim;
      WAKE_STATUS_SECONDARY <= next_sec;
      FAILURE_STATUS        <= next_fail;
      PIN_LEVEL_STATUS      <= next_level_status;
      SPI_FAIL              <= next_spi_fail;
      DEVICE_WAKE           <= low_mode && (|new_evt[3:0]);
    end
  end

  // Mode is only an input here, so an interrupt cannot alter it
  assign EVENT_OUT_N = (irq_st != IRQ_PULSE);

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  pulse_quiet_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    $fell(EVENT_OUT_N) |-> $past(run_mode))
    else $error("pulse outside run modes");
  pulse_len_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    $fell(EVENT_OUT_N) |-> !EVENT_OUT_N [*8])
    else $error("pulse too short");
  gap_len_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    $rose(EVENT_OUT_N) |-> EVENT_OUT_N [*8])
    else $error("gap too short");
  meas_level_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    HV_MEASURE_ENABLE |=> !PIN_LEVEL_STATUS)
    else $error("level not cleared in measurement");
  meas_bias_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    HV_MEASURE_ENABLE |-> !PULL_UP_ON && !PULL_DOWN_ON)
    else $error("bias active in measurement");
  bias_excl_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    !(PULL_UP_ON && PULL_DOWN_ON))
    else $error("both bias sources on");
  spi_fail_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (SLEEP_REQ && HV_MEASURE_ENABLE && sole_pin) |=> SPI_FAIL && RESTART_REQ)
    else $error("sleep request not refused");
  sticky_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (WAKE_STATUS_SECONDARY && !CLR_SECONDARY) |=> WAKE_STATUS_SECONDARY)
    else $error("secondary status lost");
  fatal_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (FATAL_EVT && !(|pend) && !fire) |=> !pend[4])
    else $error("fatal error queued an interrupt");

  pulse_c: cover property (@(posedge CORE_CLK) disable iff (!ARST_N) $fell(EVENT_OUT_N));
  pin_c: cover property (@(posedge CORE_CLK) disable iff (!ARST_N) pin_evt);
  cyc_c: cover property (@(posedge CORE_CLK) disable iff (!ARST_N) cyc_edge);
  stop_c: cover property (@(posedge CORE_CLK) disable iff (!ARST_N) stop_entry && fire);

endmodule
`default_nettype wire

// ===== sim/hwi_host_model.sv
/*
  Host-side model: times the event line and counts device wake pulses.
  Assumes one core clock and an active-low event line from the block.
*/
`timescale 1ns/1ps
`default_nettype none
module hwi_host_model (
  input  wire logic   clk,
  input  wire logic   arst_n,
  input  wire logic   event_n,
  input  wire logic   device_wake,
  output logic [31:0] pulse_count,
  output logic [31:0] wake_count,
  output logic [31:0] low_width,
  output logic [31:0] gap_min
);
  logic [31:0] run;
  logic        prev_n;
  logic        prev_wake;

  // ------------------------------------------------------------------
  // Pulse and gap timing
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run         <= 32'h0;
      prev_n      <= 1'b1;
      prev_wake   <= 1'b0;
      pulse_count <= 32'h0;
      wake_count  <= 32'h0;
      low_width   <= 32'h0;
      gap_min     <= 32'hffffffff;
    end else begin
      prev_n    <= event_n;
      prev_wake <= device_wake;
      run       <= (event_n != prev_n) ? 32'h1 : run + 32'h1;
      if (device_wake && !prev_wake) begin
        wake_count <= wake_count + 32'h1;
      end
      if (!event_n && prev_n) begin
        pulse_count <= pulse_count + 32'h1;
        // High time before the first pulse is no gap
        if (pulse_count != 32'h0 && run < gap_min) begin
          gap_min <= run;
        end
      end
      if (event_n && !prev_n) begin
        low_width <= run;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/tb_hwi_top.sv
/*
  Self-checking bench for the wake input and event interrupt block.
  Assumes the host model times the event line; package counts unchanged.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_hwi_top;
  localparam int TIMEOUT = 98000;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        pin, gpin, hs, cyc, pen, gwk, cen, cevt, fevt, fatal, meas, glob, slp, fot;
  logic        clr0, clr1, clrf, ten, tevt;
  logic [2:0]  mode;
  logic [1:0]  bias;
  logic [1:0]  st0;
  logic        st1, fst, lvl, pu, pd, route, ftd, dwk, spif, rreq, evn;
  logic [31:0] npulse, nwake, width, gap;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #5 clk = ~clk;

  hwi_top uut (
    .CORE_CLK(clk), .ARST_N(arst_n), .HV_WAKE_PIN(pin), .GPIO_WAKE_PIN(gpin),
    .HS_SWITCH_ON(hs), .MODE(mode), .CYCLIC_SENSE(cyc), .PIN_WAKE_EN(pen),
    .GPIO_IS_WAKE(gwk), .CAN_WAKE_EN(cen), .TIMER_WAKE_EN(ten), .CAN_WAKE_EVT(cevt),
    .TIMER_WAKE_EVT(tevt), .FAILURE_EVT(fevt), .FATAL_EVT(fatal),
    .BIAS_SELECT_FIELD(bias), .HV_MEASURE_ENABLE(meas), .INT_GLOBAL(glob),
    .SLEEP_REQ(slp), .FAIL_OUTPUT_TEST(fot), .CLR_PRIMARY(clr0), .CLR_SECONDARY(clr1),
    .CLR_FAILURE(clrf), .WAKE_STATUS_PRIMARY(st0), .WAKE_STATUS_SECONDARY(st1),
    .FAILURE_STATUS(fst), .PIN_LEVEL_STATUS(lvl), .PULL_UP_ON(pu), .PULL_DOWN_ON(pd),
    .MEASURE_ROUTE_ON(route), .FAIL_TEST_DRIVE(ftd), .DEVICE_WAKE(dwk),
    .SPI_FAIL(spif), .RESTART_REQ(rreq), .EVENT_OUT_N(evn));

  hwi_host_model host (
    .clk(clk), .arst_n(arst_n), .event_n(evn), .device_wake(dwk),
    .pulse_count(npulse), .wake_count(nwake), .low_width(width), .gap_min(gap));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask

  // Bounded wait for the host to see a given pulse count
  task automatic wait_pulses(input logic [31:0] n);
    for (int i = 0; i < 25000 && npulse < n; i++) begin
      step(1);
    end
    check(npulse, n);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == TIMEOUT) begin
      mismatches++;
      results;
    end
  end

  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    {pin, gpin, hs, cyc, gwk, cen, cevt, fevt, fatal, meas, glob, slp, fot} = '0;
    {clr0, clr1, clrf, ten, tevt} = '0;
    pen = 1'b1;
    mode = 3'h1;
    bias = 2'h0;
    step(10);
    arst_n = 1'b1;
    step(3);
    check(evn, 1'b1);
    check({st0, st1, fst, spif}, 5'h0);
    check({pu, pd}, 2'h0);
    done("reset");
    for (int b = 1; b < 4; b++) begin
      bias = b[1:0];
      step(2);
      check({pu, pd}, (b == 2) ? 2'h2 : 2'h1);
    end
    done("bias");
    pin = 1'b1;
    step(1000);
    pin = 1'b0;
    step(2000);
    check(st0[1], 1'b0);
    pin = 1'b1;
    step(1500);
    check(st0[1], 1'b0);
    step(200);
    check({st0[1], evn, lvl, pu}, 4'hb);
    done("filter");
    pulse(clr0);
    step(1);
    check(st0[1], 1'b0);
    pin = 1'b0;
    step(1700);
    check(st0[1], 1'b0);
    check(npulse, 32'h1);
    wait_pulses(32'h2);
    check({st0[1], evn}, 2'h2);
    check(gap >= hwi_pkg::GAP_CYCLES, 1'b1);
    step(hwi_pkg::PULSE_CYCLES);
    check(evn, 1'b1);
    check(width, 32'(hwi_pkg::PULSE_CYCLES));
    pulse(clr0);
    step(1);
    check(st0[1], 1'b0);
    done("pulse");
    pen = 1'b0;
    pin = 1'b1;
    pulse(tevt);
    pulse(fevt);
    step(12000);
    check(npulse, 32'h2);
    check(fst, 1'b0);
    done("disabled");
    glob = 1'b1;
    fatal = 1'b1;
    pulse(fevt);
    step(20);
    check(npulse, 32'h2);
    fatal = 1'b0;
    pulse(fevt);
    wait_pulses(32'h3);
    step(2);
    check(fst, 1'b1);
    pulse(clrf);
    glob = 1'b0;
    done("class");
    step(20100);
    mode = 3'h3;
    cen = 1'b1;
    step(5);
    pulse(cevt);
    step(5);
    check(st0[0], 1'b1);
    check(nwake, 32'h1);
    check(npulse, 32'h3);
    gwk = 1'b1;
    gpin = 1'b1;
    step(1700);
    check(st1, 1'b1);
    check(nwake, 32'h2);
    ten = 1'b1;
    pulse(tevt);
    step(3);
    check(nwake, 32'h3);
    pulse(clr1);
    cyc = 1'b1;
    pen = 1'b1;
    pin = 1'b0;
    hs = 1'b1;
    step(20);
    hs = 1'b0;
    step(10);
    pulse(clr0);
    pin = 1'b1;
    step(1700);
    check(st0[1], 1'b0);
    hs = 1'b1;
    step(20);
    hs = 1'b0;
    step(10);
    check(st0[1], 1'b1);
    done("sleep");
    mode = 3'h2;
    wait_pulses(32'h4);
    step(hwi_pkg::PULSE_CYCLES);
    done("stop");
    cyc = 1'b0;
    meas = 1'b1;
    fot = 1'b1;
    bias = 2'h3;
    step(5);
    check({pu, pd, route, ftd, lvl}, 5'h4);
    pulse(clr0);
    pin = 1'b0;
    step(1700);
    check({st0[1], evn}, 2'h1);
    bias = 2'h2;
    {cen, gwk, ten} = 3'h0;
    mode = 3'h1;
    pulse(slp);
    step(3);
    check({spif, rreq, pu}, 3'h6);
    meas = 1'b0;
    step(3);
    check({pu, route, ftd}, 3'h5);
    done("measure");
    mode = 3'h4;
    cen = 1'b1;
    step(5);
    pulse(cevt);
    step(20);
    check(npulse, 32'h4);
    mode = 3'h5;
    step(5);
    pulse(cevt);
    step(5);
    check(nwake, 32'h5);
    check(npulse, 32'h4);
    done("quiet modes");
    results;
  end
endmodule
`default_nettype wire
